/* rtl/gpio_port_pair_control.sv */
// Local design decision: register access over APB.
`timescale 1ns/10ps

// Summary of operation
// [RQ1] activation bits 6, 1, 0 enable ports
// [RQ2] activation resets DFh; host reset sets bit2
// [RQ3] port a direction: 0 output, 1 input; FFh
// [RQ4] port b direction same encoding, own reset
// [RQ5] output bits store, drive and read back
// [RQ6] input bits read pin; writes ignored
// [RQ7] inversion bit flips data versus pin
// [RQ8] edge on pin sets its status bit
// [RQ9] reading status clears the bits read
// [RQ10] port a registers use port a reset
// [RQ11] pins synchronised; set beats clearing read
module gpio_port_pair_control (
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [gpio_pkg::ADDR_W-1:0]   paddr,
	input  wire logic [gpio_pkg::DATA_W-1:0]   pwdata,
	output logic      [gpio_pkg::DATA_W-1:0]   prdata,
	output logic                               pready,
	output logic                               pslverr,
	input  wire logic                          resume_well_reset_n,
	input  wire logic                          host_bus_reset_n,
	input  wire logic                          port_a_reset_n,
	input  wire logic                          port_b_reset_n,
	input  wire logic [gpio_pkg::PORT_W-1:0]   port_a_pins_in,
	output logic      [gpio_pkg::PORT_W-1:0]   port_a_pins_out,
	output logic      [gpio_pkg::PORT_W-1:0]   port_a_pins_oe,
	output logic      [gpio_pkg::PORT_W-1:0]   port_b_direction_out,
	output logic                               port_a_active,
	output logic                               port_b_active,
	output logic                               port_f_active,
	output logic                               irq
);

	// ------------------------------------------------------------
	// bus request carrier
	// ------------------------------------------------------------
	gpio_pkg::apb_req_type req;

	assign req.psel    = psel;
	assign req.penable = penable;
	assign req.pwrite  = pwrite;
	assign req.paddr   = paddr;
	assign req.pwdata  = pwdata;

	// ------------------------------------------------------------
	// reset input synchronisers
	// ------------------------------------------------------------
	logic [gpio_pkg::RST_LANES-1:0] rst_meta_reg;
	logic [gpio_pkg::RST_LANES-1:0] rst_sync_reg;
	logic [gpio_pkg::RST_LANES-1:0] rst_in_n;
	logic                           resume_rst;
	logic                           host_rst;
	logic                           port_a_rst;
	logic                           port_b_rst;

	assign rst_in_n[gpio_pkg::RST_RESUME] = resume_well_reset_n;
	assign rst_in_n[gpio_pkg::RST_HOST]   = host_bus_reset_n;
	assign rst_in_n[gpio_pkg::RST_PORT_A] = port_a_reset_n;
	assign rst_in_n[gpio_pkg::RST_PORT_B] = port_b_reset_n;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rst_meta_reg <= 4'h0;
			rst_sync_reg <= 4'h0;
		end else begin
			rst_meta_reg <= rst_in_n;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	assign resume_rst = ~rst_sync_reg[gpio_pkg::RST_RESUME];
	assign host_rst   = ~rst_sync_reg[gpio_pkg::RST_HOST];
	assign port_a_rst = ~rst_sync_reg[gpio_pkg::RST_PORT_A];
	assign port_b_rst = ~rst_sync_reg[gpio_pkg::RST_PORT_B];

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	logic                           pready_reg;
	logic                           pslverr_reg;
	logic [gpio_pkg::DATA_W-1:0]    prdata_reg;
	logic                           access_phase;
	logic                           first_access;
	logic                           commit;
	logic                           wr_commit;
	logic                           rd_commit;
	logic                           addr_ok;
	logic [gpio_pkg::INDEX_W-1:0]   word_index;
	logic                           hit_act;
	logic                           hit_a_dir;
	logic                           hit_a_data;
	logic                           hit_a_inv;
	logic                           hit_a_events;
	logic                           hit_b_dir;
	logic                           hit_irq_status;
	logic                           hit_irq_mask;
	logic                           hit_any;
	logic [gpio_pkg::PORT_W-1:0]    wbyte;

	assign access_phase = req.psel & req.penable;
	assign first_access = access_phase & ~pready_reg;
	assign commit       = access_phase & pready_reg;
	assign wr_commit    = commit & req.pwrite;
	assign rd_commit    = commit & ~req.pwrite;
	assign addr_ok      = (req.paddr[11:10] == 2'h0) & (req.paddr[1:0] == 2'h0);
	assign word_index   = req.paddr[9:2];
	assign wbyte        = req.pwdata[gpio_pkg::PORT_W-1:0];

	assign hit_act        = addr_ok & (word_index == gpio_pkg::ACT_IDX);
	assign hit_a_dir      = addr_ok & (word_index == gpio_pkg::A_DIR_IDX);
	assign hit_a_data     = addr_ok & (word_index == gpio_pkg::A_DATA_IDX);
	assign hit_a_inv      = addr_ok & (word_index == gpio_pkg::A_INV_IDX);
	assign hit_a_events   = addr_ok & (word_index == gpio_pkg::A_EVENTS_IDX);
	assign hit_b_dir      = addr_ok & (word_index == gpio_pkg::B_DIR_IDX);
	assign hit_irq_status = addr_ok & (word_index == gpio_pkg::IRQ_STATUS_IDX);
	assign hit_irq_mask   = addr_ok & (word_index == gpio_pkg::IRQ_MASK_IDX);
	assign hit_any        = hit_act | hit_a_dir | hit_a_data | hit_a_inv | hit_a_events
	                      | hit_b_dir | hit_irq_status | hit_irq_mask;

	// ------------------------------------------------------------
	// register storage
	// ------------------------------------------------------------
	logic [gpio_pkg::PORT_W-1:0]    act_reg;
	logic [gpio_pkg::PORT_W-1:0]    act_next;
	logic [gpio_pkg::PORT_W-1:0]    act_written;
	logic [gpio_pkg::PORT_W-1:0]    a_dir_reg;
	logic [gpio_pkg::PORT_W-1:0]    a_dir_next;
	logic [gpio_pkg::PORT_W-1:0]    a_data_reg;
	logic [gpio_pkg::PORT_W-1:0]    a_data_next;
	logic [gpio_pkg::PORT_W-1:0]    a_inv_reg;
	logic [gpio_pkg::PORT_W-1:0]    a_inv_next;
	logic [gpio_pkg::PORT_W-1:0]    b_dir_reg;
	logic [gpio_pkg::PORT_W-1:0]    b_dir_next;
	logic [gpio_pkg::PORT_W-1:0]    irq_status_reg;
	logic [gpio_pkg::PORT_W-1:0]    irq_status_next;
	logic [gpio_pkg::PORT_W-1:0]    irq_mask_reg;
	logic [gpio_pkg::PORT_W-1:0]    irq_mask_next;
	logic [gpio_pkg::PORT_W-1:0]    event_clear;
	logic [gpio_pkg::PORT_W-1:0]    irq_w1c;
	gpio_pkg::pin_event_type        a_events;

	// ------------------------------------------------------------
	// activation register
	// ------------------------------------------------------------
	assign act_written = (wr_commit & hit_act) ? wbyte : act_reg; // [RQ1]

	always_comb begin
		act_next = act_written;
		if (host_rst) begin
			act_next[gpio_pkg::ACT_HOST_BIT] = gpio_pkg::ACT_RESET[gpio_pkg::ACT_HOST_BIT]; // [RQ2]
		end
		if (resume_rst) begin
			act_next = gpio_pkg::ACT_RESET; // [RQ2]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			act_reg <= gpio_pkg::ACT_RESET; // [RQ2]
		end else begin
			act_reg <= act_next;
		end
	end

	// ------------------------------------------------------------
	// port a direction, data and inversion
	// ------------------------------------------------------------
	assign a_dir_next = port_a_rst ? gpio_pkg::DIR_RESET // [RQ10]
	                  : (wr_commit & hit_a_dir) ? wbyte : a_dir_reg; // [RQ3]

	assign a_data_next = port_a_rst ? gpio_pkg::DATA_RESET // [RQ10]
	                   : (wr_commit & hit_a_data)
	                     ? ((a_data_reg & a_dir_reg) | (wbyte & ~a_dir_reg)) // [RQ6]
	                     : a_data_reg; // [RQ5]

	assign a_inv_next = port_a_rst ? gpio_pkg::INV_RESET // [RQ10]
	                  : (wr_commit & hit_a_inv) ? wbyte : a_inv_reg; // [RQ7]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			a_dir_reg <= gpio_pkg::DIR_RESET; // [RQ3]
		end else begin
			a_dir_reg <= a_dir_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			a_data_reg <= gpio_pkg::DATA_RESET; // [RQ5]
		end else begin
			a_data_reg <= a_data_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			a_inv_reg <= gpio_pkg::INV_RESET; // [RQ7]
		end else begin
			a_inv_reg <= a_inv_next;
		end
	end

	// ------------------------------------------------------------
	// port b direction
	// ------------------------------------------------------------
	assign b_dir_next = port_b_rst ? gpio_pkg::DIR_RESET // [RQ4]
	                  : (wr_commit & hit_b_dir) ? wbyte : b_dir_reg; // [RQ4]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			b_dir_reg <= gpio_pkg::DIR_RESET; // [RQ4]
		end else begin
			b_dir_reg <= b_dir_next;
		end
	end

	// ------------------------------------------------------------
	// port a edge events
	// ------------------------------------------------------------
	assign event_clear = (rd_commit & hit_a_events) ? prdata_reg[gpio_pkg::PORT_W-1:0]
	                                                : 8'h00; // [RQ9]

	edge_event_capture u_port_a_events (
		.pclk       (pclk),
		.presetn    (presetn),
		.clear_sync (port_a_rst),
		.enable     (act_reg[gpio_pkg::ACT_A_BIT]),
		.pin_async  (port_a_pins_in),
		.clear_bits (event_clear),
		.events     (a_events)
	);

	// ------------------------------------------------------------
	// interrupt status and mask
	// ------------------------------------------------------------
	assign irq_w1c = (wr_commit & hit_irq_status) ? wbyte : 8'h00;

	assign irq_status_next = a_events.edge_pulse | (irq_status_reg & ~irq_w1c);

	assign irq_mask_next = (wr_commit & hit_irq_mask) ? wbyte : irq_mask_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status_reg <= gpio_pkg::IRQ_RESET;
		end else begin
			irq_status_reg <= irq_status_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask_reg <= gpio_pkg::MASK_RESET;
		end else begin
			irq_mask_reg <= irq_mask_next;
		end
	end

	// ------------------------------------------------------------
	// read data selection
	// ------------------------------------------------------------
	logic [gpio_pkg::PORT_W-1:0] a_data_view;
	logic [gpio_pkg::PORT_W-1:0] read_byte;

	assign a_data_view = (a_data_reg & ~a_dir_reg) // [RQ5]
	                   | ((a_events.level ^ a_inv_reg) & a_dir_reg); // [RQ6] [RQ7]

	assign read_byte = hit_act        ? act_reg
	                 : hit_a_dir      ? a_dir_reg
	                 : hit_a_data     ? a_data_view
	                 : hit_a_inv      ? a_inv_reg
	                 : hit_a_events   ? a_events.status // [RQ8]
	                 : hit_b_dir      ? b_dir_reg
	                 : hit_irq_status ? irq_status_reg
	                 : hit_irq_mask   ? irq_mask_reg
	                 : 8'h00;

	// ------------------------------------------------------------
	// apb response, one wait state
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
		end else begin
			pready_reg <= first_access;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0000_0000;
		end else if (first_access) begin
			prdata_reg <= req.pwrite ? 32'h0000_0000 : {24'h00_0000, read_byte};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr_reg <= 1'b0;
		end else begin
			pslverr_reg <= first_access & ~hit_any;
		end
	end

	assign prdata  = prdata_reg;
	assign pready  = pready_reg;
	assign pslverr = pslverr_reg;

	// ------------------------------------------------------------
	// pin and status outputs
	// ------------------------------------------------------------
	logic [gpio_pkg::PORT_W-1:0] pins_out_reg;
	logic [gpio_pkg::PORT_W-1:0] pins_oe_reg;
	logic                        irq_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pins_out_reg <= 8'h00;
			pins_oe_reg  <= 8'h00;
		end else begin
			pins_out_reg <= a_data_reg ^ a_inv_reg; // [RQ7]
			pins_oe_reg  <= ~a_dir_reg & {8{act_reg[gpio_pkg::ACT_A_BIT]}}; // [RQ3] [RQ1]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(irq_status_reg & irq_mask_reg);
		end
	end

	assign port_a_pins_out      = pins_out_reg;
	assign port_a_pins_oe       = pins_oe_reg;
	assign port_b_direction_out = b_dir_reg;
	assign port_a_active        = act_reg[gpio_pkg::ACT_A_BIT];
	assign port_b_active        = act_reg[gpio_pkg::ACT_B_BIT];
	assign port_f_active        = act_reg[gpio_pkg::ACT_F_BIT];
	assign irq                  = irq_reg;

endmodule

/* rtl/gpio_pkg.sv */
package gpio_pkg;

	// ------------------------------------------------------------
	// bus and register geometry
	// ------------------------------------------------------------
	localparam int ADDR_W   = 12;
	localparam int DATA_W   = 32;
	localparam int PORT_W   = 8;
	localparam int INDEX_W  = 8;

	// register indices, byte address is four times the index
	localparam logic [INDEX_W-1:0] ACT_IDX        = 8'h30;
	localparam logic [INDEX_W-1:0] A_DIR_IDX      = 8'he0;
	localparam logic [INDEX_W-1:0] A_DATA_IDX     = 8'he1;
	localparam logic [INDEX_W-1:0] A_INV_IDX      = 8'he2;
	localparam logic [INDEX_W-1:0] A_EVENTS_IDX   = 8'he3;
	localparam logic [INDEX_W-1:0] B_DIR_IDX      = 8'he4;
	localparam logic [INDEX_W-1:0] IRQ_STATUS_IDX = 8'hf0;
	localparam logic [INDEX_W-1:0] IRQ_MASK_IDX   = 8'hf1;

	// ------------------------------------------------------------
	// activation register fields and reset values
	// ------------------------------------------------------------
	localparam int ACT_A_BIT    = 0;
	localparam int ACT_B_BIT    = 1;
	localparam int ACT_HOST_BIT = 2;
	localparam int ACT_F_BIT    = 6;

	localparam logic [PORT_W-1:0] ACT_RESET    = 8'hdf;
	localparam logic [PORT_W-1:0] DIR_RESET    = 8'hff;
	localparam logic [PORT_W-1:0] DATA_RESET   = 8'h00;
	localparam logic [PORT_W-1:0] INV_RESET    = 8'h00;
	localparam logic [PORT_W-1:0] EVENTS_RESET = 8'h00;
	localparam logic [PORT_W-1:0] IRQ_RESET    = 8'h00;
	localparam logic [PORT_W-1:0] MASK_RESET   = 8'h00;

	// reset synchroniser lanes
	localparam int RST_RESUME = 0;
	localparam int RST_HOST   = 1;
	localparam int RST_PORT_A = 2;
	localparam int RST_PORT_B = 3;
	localparam int RST_LANES  = 4;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} apb_req_type;

	typedef struct packed {
		logic [PORT_W-1:0] level;
		logic [PORT_W-1:0] edge_pulse;
		logic [PORT_W-1:0] status;
	} pin_event_type;

endpackage

/* rtl/edge_event_capture.sv */
`timescale 1ns/10ps
module edge_event_capture (
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	input  wire logic                          clear_sync,
	input  wire logic                          enable,
	input  wire logic [gpio_pkg::PORT_W-1:0]   pin_async,
	input  wire logic [gpio_pkg::PORT_W-1:0]   clear_bits,
	output gpio_pkg::pin_event_type            events
);

	// ------------------------------------------------------------
	// per pin synchroniser, edge detect and sticky status
	// ------------------------------------------------------------
	logic [gpio_pkg::PORT_W-1:0] meta_reg;
	logic [gpio_pkg::PORT_W-1:0] sync_reg;
	logic [gpio_pkg::PORT_W-1:0] prev_reg;
	logic [gpio_pkg::PORT_W-1:0] status_reg;
	logic [gpio_pkg::PORT_W-1:0] edge_pulse;
	logic [2:0]                  warm_reg;

	// edges count only once both history flops hold real pin samples
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			warm_reg <= 3'h0;
		end else begin
			warm_reg <= {warm_reg[1:0], 1'b1};
		end
	end

	genvar i;
	generate
		for (i = 0; i < gpio_pkg::PORT_W; i++) begin : g_bit
			assign edge_pulse[i] = enable & warm_reg[2] & (sync_reg[i] ^ prev_reg[i]); // [RQ8]
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					meta_reg[i]   <= 1'b0;
					sync_reg[i]   <= 1'b0;
					prev_reg[i]   <= 1'b0;
					status_reg[i] <= 1'b0;
				end else begin
					meta_reg[i] <= pin_async[i]; // [RQ11]
					sync_reg[i] <= meta_reg[i]; // [RQ11]
					prev_reg[i] <= sync_reg[i];
					if (clear_sync) begin
						status_reg[i] <= gpio_pkg::EVENTS_RESET[i]; // [RQ10]
					end else begin
						status_reg[i] <= edge_pulse[i] | (status_reg[i] & ~clear_bits[i]); // [RQ11]
					end
				end
			end
		end
	endgenerate

	assign events.level      = sync_reg;
	assign events.edge_pulse = edge_pulse;
	assign events.status     = status_reg;

endmodule

/* dv/port_a_pin_model.sv */
`timescale 1ns/10ps
// ----------------------------------------
// outside world at the port a pins
// ----------------------------------------
module port_a_pin_model (
	input  wire logic [gpio_pkg::PORT_W-1:0] pins_out,
	input  wire logic [gpio_pkg::PORT_W-1:0] pins_oe,
	input  wire logic [gpio_pkg::PORT_W-1:0] ext_level,
	output logic      [gpio_pkg::PORT_W-1:0] pins_in
);
	// driven bits follow the port, released bits show the far side level
	assign pins_in = (pins_out & pins_oe) | (ext_level & ~pins_oe);
endmodule

/* dv/gpio_port_pair_control_properties.sv */
`timescale 1ns/10ps
module gpio_port_pair_control_properties (
	input wire logic                        pclk,
	input wire logic                        presetn,
	input wire logic                        psel,
	input wire logic                        penable,
	input wire logic                        pwrite,
	input wire logic [gpio_pkg::ADDR_W-1:0] paddr,
	input wire logic [gpio_pkg::DATA_W-1:0] pwdata,
	input wire logic [gpio_pkg::DATA_W-1:0] prdata,
	input wire logic                        pready,
	input wire logic                        pslverr,
	input wire logic                        resume_well_reset_n,
	input wire logic                        host_bus_reset_n,
	input wire logic                        port_a_reset_n,
	input wire logic                        port_b_reset_n,
	input wire logic [gpio_pkg::PORT_W-1:0] port_a_pins_in,
	input wire logic [gpio_pkg::PORT_W-1:0] port_a_pins_out,
	input wire logic [gpio_pkg::PORT_W-1:0] port_a_pins_oe,
	input wire logic [gpio_pkg::PORT_W-1:0] port_b_direction_out,
	input wire logic                        port_a_active,
	input wire logic                        port_b_active,
	input wire logic                        port_f_active,
	input wire logic                        irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ----------------------------------------
	// cycles since the port a reset was last low
	// ----------------------------------------
	logic [3:0] quiet_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			quiet_reg <= 4'h0;
		end else if (!port_a_reset_n) begin
			quiet_reg <= 4'h0;
		end else if (quiet_reg != 4'hf) begin
			quiet_reg <= quiet_reg + 4'h1;
		end
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("pready stayed high");
	a_ready_on_access: assert property (psel && penable && !pready |=> pready)
		else $error("pready late");
	a_idle_no_ready: assert property (!psel |-> !pready)
		else $error("pready without select");
	a_err_misaligned: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
		else $error("misaligned access accepted");
	a_err_high_addr: assert property (pready && paddr[11:10] != 2'h0 |-> pslverr)
		else $error("unmapped access accepted");
	a_dir_no_err: assert property (pready && paddr == 12'h380 |-> !pslverr)
		else $error("direction access refused");
	a_read_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("read upper bits set");
	a_oe_needs_active: assert property (!port_a_active && $past(!port_a_active)
		|-> port_a_pins_oe == 8'h00)
		else $error("inactive port drives");
	a_pins_by_write: assert property ($changed(port_a_pins_out) && quiet_reg == 4'hf
		|-> $past(pready && pwrite, 2))
		else $error("pins changed without write");
	c_write: cover property (pready && pwrite);
	c_refused: cover property (pready && pslverr);
	c_irq: cover property ($rose(irq));
endmodule
bind gpio_port_pair_control gpio_port_pair_control_properties gpio_port_pair_control_properties_inst (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.resume_well_reset_n(resume_well_reset_n), .host_bus_reset_n(host_bus_reset_n),
	.port_a_reset_n(port_a_reset_n), .port_b_reset_n(port_b_reset_n),
	.port_a_pins_in(port_a_pins_in), .port_a_pins_out(port_a_pins_out),
	.port_a_pins_oe(port_a_pins_oe), .port_b_direction_out(port_b_direction_out),
	.port_a_active(port_a_active), .port_b_active(port_b_active),
	.port_f_active(port_f_active), .irq(irq));

/* dv/gpio_port_pair_control_bench.sv */
`timescale 1ns/10ps
module gpio_port_pair_control_bench;
	localparam logic [11:0] ACT = {2'h0, gpio_pkg::ACT_IDX, 2'h0};
	localparam logic [11:0] DIR = {2'h0, gpio_pkg::A_DIR_IDX, 2'h0};
	localparam logic [11:0] DAT = {2'h0, gpio_pkg::A_DATA_IDX, 2'h0};
	localparam logic [11:0] INV = {2'h0, gpio_pkg::A_INV_IDX, 2'h0};
	localparam logic [11:0] EVT = {2'h0, gpio_pkg::A_EVENTS_IDX, 2'h0};
	localparam logic [11:0] BDR = {2'h0, gpio_pkg::B_DIR_IDX, 2'h0};
	localparam logic [11:0] IST = {2'h0, gpio_pkg::IRQ_STATUS_IDX, 2'h0};
	localparam logic [11:0] IMK = {2'h0, gpio_pkg::IRQ_MASK_IDX, 2'h0};
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, ev;
	logic        a_act, b_act, f_act;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rv, rv2;
	logic [3:0]  rsn;
	logic [7:0]  ext_level, pins_in, pins_out, pins_oe, b_dir;
	logic [7:0]  acts [3] = '{8'h01, 8'h02, 8'h40};
	logic [11:0] bad [3] = '{12'h381, 12'h3fc, 12'hc00};
	int          err_count, samples_checked;
	gpio_port_pair_control gpio_port_pair_control_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.resume_well_reset_n(rsn[gpio_pkg::RST_RESUME]),
		.host_bus_reset_n(rsn[gpio_pkg::RST_HOST]),
		.port_a_reset_n(rsn[gpio_pkg::RST_PORT_A]), .port_b_reset_n(rsn[gpio_pkg::RST_PORT_B]),
		.port_a_pins_in(pins_in), .port_a_pins_out(pins_out), .port_a_pins_oe(pins_oe),
		.port_b_direction_out(b_dir), .port_a_active(a_act), .port_b_active(b_act),
		.port_f_active(f_act), .irq(irq));
	port_a_pin_model port_a_pin_model_inst (
		.pins_out(pins_out), .pins_oe(pins_oe), .ext_level(ext_level), .pins_in(pins_in));
	// ----------------------------------------
	// clock, watchdog and helpers
	// ----------------------------------------
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	initial begin
		repeat (5000) @(posedge pclk);
		err_count++;
		finish_test;
	end
	task finish_test;
		if (err_count == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rv = prdata;
		ev = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk("pready", 32'(pready), 32'h1);
	endtask
	task wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d});
	endtask
	task rd(input string nm, input logic [11:0] a, input logic [7:0] exp);
		apb(1'b0, a, 32'h0);
		chk(nm, rv, {24'h0, exp});
	endtask
	task sub_reset(input int k);
		@(posedge pclk);
		rsn[k] <= 1'b0;
		repeat (4) @(posedge pclk);
		rsn[k] <= 1'b1;
		repeat (4) @(posedge pclk);
	endtask
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		rsn = 4'hf;
		ext_level = 8'h03;
		err_count = 0;
		samples_checked = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		rd("act", ACT, 8'hdf);
		rd("a_dir", DIR, 8'hff);
		rd("a_data", DAT, 8'h03);
		rd("a_inv", INV, 8'h00);
		rd("a_events", EVT, 8'h00);
		rd("b_dir", BDR, 8'hff);
		chk("b_dir_out", 32'(b_dir), 32'hff);
		chk("actives", 32'({f_act, b_act, a_act}), 32'h7);
		for (int i = 0; i < 3; i++) begin
			wr(ACT, acts[i]);
			repeat (2) @(posedge pclk);
			chk("actives", 32'({f_act, b_act, a_act}), 32'({acts[i][6], acts[i][1:0]}));
		end
		wr(ACT, 8'hdf);
		wr(DIR, 8'h0f);
		wr(DAT, 8'ha5);
		repeat (2) @(posedge pclk);
		chk("oe", 32'(pins_oe), 32'hf0);
		chk("out", 32'(pins_out & 8'hf0), 32'ha0);
		rd("a_data", DAT, 8'ha3);
		wr(INV, 8'hff);
		repeat (2) @(posedge pclk);
		chk("out_inv", 32'(pins_out & 8'hf0), 32'h50);
		rd("a_data_inv", DAT, 8'hac);
		repeat (5) @(posedge pclk);
		rd("a_events", EVT, 8'hf0);
		rd("a_events", EVT, 8'h00);
		chk("irq", 32'(irq), 32'h0);
		wr(IMK, 8'h10);
		repeat (2) @(posedge pclk);
		chk("irq", 32'(irq), 32'h1);
		wr(IST, 8'h10);
		repeat (2) @(posedge pclk);
		chk("irq", 32'(irq), 32'h0);
		rd("irq_status", IST, 8'he0);
		wr(IST, 8'he0);
		rd("irq_status", IST, 8'h00);
		ext_level <= 8'h01;
		apb(1'b0, EVT, 32'h0);
		rv2 = rv;
		apb(1'b0, EVT, 32'h0);
		chk("race_events", rv2 | rv, 32'h02);
		rd("a_events", EVT, 8'h00);
		wr(ACT, 8'hde);
		ext_level <= 8'h03;
		repeat (5) @(posedge pclk);
		rd("idle_events", EVT, 8'h00);
		chk("idle_oe", 32'(pins_oe), 32'h0);
		wr(ACT, 8'hdf);
		for (int i = 0; i < 3; i++) begin
			wr(bad[i], 8'hff);
			chk("w_err", 32'(ev), 32'h1);
			apb(1'b0, bad[i], 32'h0);
			chk("r_err", {rv[30:0], ev}, 32'h1);
		end
		rd("reenable_events", EVT, 8'h50);
		wr(EVT, 8'hff);
		rd("ro_events", EVT, 8'h00);
		wr(DIR, 8'h00);
		wr(INV, 8'h55);
		wr(BDR, 8'h3c);
		sub_reset(gpio_pkg::RST_PORT_A);
		rd("a_dir", DIR, 8'hff);
		rd("a_inv", INV, 8'h00);
		rd("b_dir_kept", BDR, 8'h3c);
		wr(DIR, 8'h00);
		rd("a_data", DAT, 8'h00);
		sub_reset(gpio_pkg::RST_PORT_B);
		rd("b_dir", BDR, 8'hff);
		chk("b_dir_out", 32'(b_dir), 32'hff);
		wr(ACT, 8'h00);
		sub_reset(gpio_pkg::RST_HOST);
		rd("act_host", ACT, 8'h04);
		sub_reset(gpio_pkg::RST_RESUME);
		rd("act_resume", ACT, 8'hdf);
		finish_test;
	end
endmodule
